// ==== dv/ang_regs_tb.sv ====
/*
 Self-checking bench for the gain control register bank: register access,
 gain readback clamping, right noise gate decode and both silence detectors.
 Assumes ang_pkg is compiled first; debounce unit shortened to 4 cycles.
*/
`timescale 1ns/10ps
`define CHK(got, exp, msg) begin checked++; if ((got) !== (exp)) begin n_fail++; \
	$display("MISMATCH t=%0t %s got=%0h exp=%0h", $time, msg, got, exp); end end
module ang_regs_tb;
	import ang_pkg::*;
	// ----------------------------------------------------------------
	// stimulus and observation signals
	// ----------------------------------------------------------------
	localparam int UNIT = 4;
	logic             i_sys_clk                = 1'b0;
	logic             i_reset_n                = 1'b0;
	logic [7:0]       i_reg_addr               = 8'h00;
	logic             i_reg_wr_en              = 1'b0;
	logic [7:0]       i_reg_wr_data            = 8'h00;
	logic             i_reg_rd_en              = 1'b0;
	logic             i_double_rate_audio_mode = 1'b0;
	logic             i_right_agc_enable       = 1'b0;
	logic [6:0]       i_right_max_gain         = 7'h7F;
	logic             i_left_gain_vld          = 1'b0;
	logic [7:0]       i_left_gain              = 8'h00;
	logic             i_right_gain_vld         = 1'b0;
	logic [7:0]       i_right_gain             = 8'h00;
	logic             i_left_below             = 1'b0;
	logic [6:0]       i_right_level_db         = 7'h00;
	logic [7:0]       o_reg_rd_data;
	ang_rcfg_t        o_right_cfg;
	logic             o_left_silence;
	logic             o_right_silence;
	int               n_fail                   = 0;
	int               checked                  = 0;
	logic [7:0]       seed                     = 8'h54;
	logic [7:0]       rd_val;
	logic [7:0]       lg_model                 = 8'h00;
	logic [7:0]       rg_model                 = 8'h00;
	logic [7:0]       d;
	int               nc[5]                    = '{0, 1, 3, 8, 31};
	int               sc[5]                    = '{0, 2, 7, 1, 0};

	// free-running clock, 5 ns period
	always #2.5 i_sys_clk = ~i_sys_clk;

	ang_regs #(.P_DEB_UNIT_CYC(32'(UNIT))) i_dut (
		.i_sys_clk                (i_sys_clk),
		.i_reset_n                (i_reset_n),
		.i_reg_addr               (i_reg_addr),
		.i_reg_wr_en              (i_reg_wr_en),
		.i_reg_wr_data            (i_reg_wr_data),
		.i_reg_rd_en              (i_reg_rd_en),
		.o_reg_rd_data            (o_reg_rd_data),
		.i_double_rate_audio_mode (i_double_rate_audio_mode),
		.i_right_agc_enable       (i_right_agc_enable),
		.i_right_max_gain         (i_right_max_gain),
		.i_left_gain_vld          (i_left_gain_vld),
		.i_left_gain              (i_left_gain),
		.i_right_gain_vld         (i_right_gain_vld),
		.i_right_gain             (i_right_gain),
		.i_left_below             (i_left_below),
		.i_right_level_db         (i_right_level_db),
		.o_right_cfg              (o_right_cfg),
		.o_left_silence           (o_left_silence),
		.o_right_silence          (o_right_silence)
	);

	// ----------------------------------------------------------------
	// reference model helpers
	// ----------------------------------------------------------------
	// maximal-length 8-bit sequence, never reaches zero from a nonzero seed
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	function automatic logic [7:0] clamp(input logic [7:0] v, input logic [7:0] hi);
		if ($signed(v) < $signed(GAIN_MIN)) return GAIN_MIN;
		if ($signed(v) > $signed(hi)) return hi;
		return v;
	endfunction

	// debounce length in cycles for a code, given the half-ms unit
	function automatic int deb(input int c, input int u);
		if (c == 0) return 0;
		if (c <= 7) return u << (c - 1);
		return u * 128 * (c - 7);
	endfunction

	// ----------------------------------------------------------------
	// drivers and checks
	// ----------------------------------------------------------------
	task print_verdict;
		$display("checked=%0d n_fail=%0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge i_sys_clk);
		i_reg_addr <= a;
		i_reg_wr_data <= v;
		i_reg_wr_en <= 1'b1;
		@(posedge i_sys_clk);
		i_reg_wr_en <= 1'b0;
	endtask

	// read data is registered, so it is sampled after the taking edge
	task rd(input logic [7:0] a);
		@(posedge i_sys_clk);
		i_reg_addr <= a;
		i_reg_rd_en <= 1'b1;
		@(posedge i_sys_clk);
		i_reg_rd_en <= 1'b0;
		#1;
		rd_val = o_reg_rd_data;
	endtask

	task settle(input int n);
		repeat (n) @(posedge i_sys_clk);
		#1;
	endtask

	task chk_cfg(input logic [7:0] r);
		logic [6:0] cap;
		cap = (i_right_max_gain > MAX_GAIN_SAT) ? MAX_GAIN_SAT : i_right_max_gain;
		`CHK(o_right_cfg.noise_det_en, (r[5:1] != 5'h00) && i_right_agc_enable, "noise detect enable")
		`CHK(o_right_cfg.hyst_db, (r[7:6] == HYST_OFF) ? 2'h0 : r[7:6] + 2'h1, "hysteresis")
		`CHK(o_right_cfg.thr_db, (r[5:1] == 5'h00 || !i_right_agc_enable) ? 7'h00 : 7'(28 + 2 * r[5:1]), "threshold")
		`CHK(o_right_cfg.clip_en, r[0], "clip stepping")
		`CHK(o_right_cfg.agc_active, i_right_agc_enable, "right enable")
		`CHK(o_right_cfg.gain_cap, cap, "gain cap")
	endtask

	// a run of one level must last its debounce count plus one edge
	task det_run(input logic lvl, input int exp_n);
		int n;
		n = 0;
		@(posedge i_sys_clk);
		i_left_below <= lvl;
		do begin
			@(posedge i_sys_clk);
			#1;
			n++;
		end while (o_left_silence !== lvl && n < 20000);
		`CHK(n, exp_n, "left debounce length")
		if (n >= 20000)
			print_verdict();
	endtask

	task rlev(input logic [6:0] lvl, input logic exp);
		@(posedge i_sys_clk);
		i_right_level_db <= lvl;
		settle(3);
		`CHK(o_right_silence, exp, "right silence")
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (8) @(posedge i_sys_clk);
		i_reset_n <= 1'b1;
		settle(1);
		rd(ADDR_RIGHT_NG_CTRL);
		`CHK(rd_val, 8'h00, "right control reset")
		rd(ADDR_LEFT_GAIN);
		`CHK(rd_val, GAIN_RST, "left gain reset")
		rd(ADDR_RIGHT_GAIN);
		`CHK(rd_val, GAIN_RST, "right gain reset")
		rd(ADDR_LEFT_DEBOUNCE);
		`CHK(rd_val, 8'h00, "debounce reset")
		chk_cfg(8'h00);
		wr(8'h40, 8'hA5);
		rd(8'h40);
		`CHK(rd_val, 8'h00, "unmapped read")
		$display("test reset done");

		// every hysteresis code, threshold ends and clip both ways
		for (int i = 0; i < 8; i++) begin
			seed = lfsr(seed);
			@(posedge i_sys_clk);
			i_right_max_gain <= (i == 0) ? 7'h78 : seed[6:0];
			i_right_agc_enable <= seed[7];
			d = {2'(i % 4), (i == 0) ? 5'h00 : (i == 1) ? 5'h1F : (i == 2) ? 5'h01 : seed[5:1], seed[0]};
			wr(ADDR_RIGHT_NG_CTRL, d);
			settle(1);
			chk_cfg(d);
			rd(ADDR_RIGHT_NG_CTRL);
			`CHK(rd_val, d, "right control readback")
		end
		$display("test right control done");

		// applied gain updates, clamping, and ignored writes
		for (int i = 0; i < 16; i++) begin
			seed = lfsr(seed);
			@(posedge i_sys_clk);
			i_right_max_gain <= (i == 0) ? 7'h7F : seed[6:0];
			i_right_agc_enable <= (i < 2) ? 1'b1 : seed[3];
			seed = lfsr(seed);
			@(posedge i_sys_clk);
			i_left_gain <= seed;
			i_left_gain_vld <= 1'b1;
			lg_model = clamp(seed, GAIN_MAX);
			seed = lfsr(seed);
			i_right_gain <= seed;
			i_right_gain_vld <= 1'b1;
			if (i_right_agc_enable)
				rg_model = clamp(seed, {1'b0, (i_right_max_gain > MAX_GAIN_SAT) ? MAX_GAIN_SAT : i_right_max_gain});
			@(posedge i_sys_clk);
			i_left_gain_vld <= 1'b0;
			i_right_gain_vld <= 1'b0;
			wr(ADDR_LEFT_GAIN, ~lg_model);
			wr(ADDR_RIGHT_GAIN, ~rg_model);
			rd(ADDR_LEFT_GAIN);
			`CHK(rd_val, lg_model, "left gain")
			rd(ADDR_RIGHT_GAIN);
			`CHK(rd_val, rg_model, "right gain")
		end
		$display("test gain readback done");

		// left detector across linear and long debounce codes
		for (int i = 0; i < 5; i++) begin
			d = {5'(nc[i]), 3'(sc[i])};
			wr(ADDR_LEFT_DEBOUNCE, d);
			rd(ADDR_LEFT_DEBOUNCE);
			`CHK(rd_val, d, "debounce readback")
			det_run(1'b1, deb(nc[i], UNIT) + 1);
			det_run(1'b0, deb(sc[i], UNIT) + 1);
		end
		@(posedge i_sys_clk);
		i_double_rate_audio_mode <= 1'b1;
		wr(ADDR_LEFT_DEBOUNCE, 8'h19);
		det_run(1'b1, deb(3, UNIT / 2) + 1);
		det_run(1'b0, deb(1, UNIT / 2) + 1);
		@(posedge i_sys_clk);
		i_double_rate_audio_mode <= 1'b0;
		$display("test left detector done");

		// right detector with 1 dB hysteresis at -30 dB, then hysteresis off
		@(posedge i_sys_clk);
		i_right_agc_enable <= 1'b1;
		wr(ADDR_RIGHT_NG_CTRL, 8'h02);
		rlev(7'h28, 1'b1);
		rlev(7'h1E, 1'b1);
		rlev(7'h1C, 1'b0);
		rlev(7'h1F, 1'b1);
		wr(ADDR_RIGHT_NG_CTRL, 8'hC2);
		rlev(7'h1E, 1'b1);
		rlev(7'h1D, 1'b0);
		rlev(7'h28, 1'b1);
		wr(ADDR_RIGHT_NG_CTRL, 8'h00);
		rlev(7'h28, 1'b0);
		wr(ADDR_RIGHT_NG_CTRL, 8'h02);
		rlev(7'h28, 1'b1);
		@(posedge i_sys_clk);
		i_right_agc_enable <= 1'b0;
		rlev(7'h28, 1'b0);
		$display("test right detector done");
		print_verdict();
	end

	// overall limit in case a handshake never completes
	initial begin
		#500000;
		n_fail++;
		print_verdict();
	end
endmodule

// ==== logic/ang_debounce.sv ====
/*
 Silence / signal-presence debouncer for one gain control channel.
 Assumes i_below comes from logic on the same clock; counts are in cycles.
*/
`timescale 1ns/10ps
module ang_debounce (
	input  wire logic        i_sys_clk,
	input  wire logic        i_reset_n,
	input  wire logic        i_en,
	input  wire logic        i_below,
	input  wire logic [31:0] i_noise_cyc,
	input  wire logic [31:0] i_sig_cyc,
	output logic             o_silent
);
	import ang_pkg::*;

	typedef enum logic {
		DB_SIGNAL = 1'b0,
		DB_QUIET  = 1'b1
	} ang_db_state_t;

	ang_db_state_t state_reg;
	logic [31:0]   cnt_reg;

	// ----------------------------------------------------------------
	// state and run counter
	// ----------------------------------------------------------------
	// a run must last count+1 cycles; any break restarts the count
	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n || !i_en) begin
			state_reg <= DB_SIGNAL;
			cnt_reg   <= '0;
		end else begin
			case (state_reg)
				DB_SIGNAL: begin
					if (!i_below) begin
						cnt_reg <= '0;
					end else if (cnt_reg >= i_noise_cyc) begin
						state_reg <= DB_QUIET;
						cnt_reg   <= '0;
					end else begin
						cnt_reg <= cnt_reg + 32'h1;
					end
				end
				DB_QUIET: begin
					if (i_below) begin
						cnt_reg <= '0;
					end else if (cnt_reg >= i_sig_cyc) begin
						state_reg <= DB_SIGNAL;
						cnt_reg   <= '0;
					end else begin
						cnt_reg <= cnt_reg + 32'h1;
					end
				end
				default: begin
					state_reg <= DB_SIGNAL;
					cnt_reg   <= '0;
				end
			endcase
		end
	end

	assign o_silent = (state_reg == DB_QUIET);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_quiet_after_run;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		(i_en && !o_silent && i_below && cnt_reg >= i_noise_cyc) |=> (o_silent || !$past(i_en, 1));
	endproperty
	a_quiet_after_run: assert property (p_quiet_after_run) else $error("silence not declared after run");

	property p_break_restarts;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		(!o_silent && !i_below) |=> (cnt_reg == 32'h0) && !o_silent;
	endproperty
	a_break_restarts: assert property (p_break_restarts) else $error("noise run not restarted");

endmodule

// ==== logic/ang_pkg.sv ====
/*
 Shared constants and types for the recording-path gain control register bank:
 register offsets, field layouts, reset values and debounce timing.
 Assumes one 200 MHz system clock shared by the bank and the gain loop.
*/
package ang_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_RIGHT_NG_CTRL  = 8'h1F;
	localparam logic [7:0] ADDR_LEFT_GAIN      = 8'h20;
	localparam logic [7:0] ADDR_RIGHT_GAIN     = 8'h21;
	localparam logic [7:0] ADDR_LEFT_DEBOUNCE  = 8'h22;
	localparam logic [7:0] RD_UNMAPPED         = 8'h00;

	// right noise gate control layout: hyst[7:6] thr[5:1] clip[0]
	typedef struct packed {
		logic [1:0] hyst;
		logic [4:0] thr;
		logic       clip;
	} ang_rctl_t;

	// left debounce layout: noise[7:3] sig[2:0]
	typedef struct packed {
		logic [4:0] noise;
		logic [2:0] sig;
	} ang_dbn_t;

	// decoded right channel settings handed to the gain loop
	typedef struct packed {
		logic       noise_det_en;
		logic [1:0] hyst_db;
		logic [6:0] thr_db;
		logic       clip_en;
		logic       agc_active;
		logic [6:0] gain_cap;
	} ang_rcfg_t;

	localparam ang_rctl_t RCTL_RST  = '{hyst: 2'h0, thr: 5'h00, clip: 1'b0};
	localparam ang_dbn_t  DBN_RST   = '{noise: 5'h00, sig: 3'h0};
	localparam logic [7:0] GAIN_RST = 8'h00;

	// ----------------------------------------------------------------
	// field encodings
	// ----------------------------------------------------------------
	localparam logic [1:0] HYST_OFF      = 2'h3;
	localparam logic [4:0] THR_OFF       = 5'h00;
	localparam logic [6:0] THR_BASE_DB   = 7'h1C;
	localparam logic [7:0] GAIN_MIN      = 8'hE8;
	localparam logic [7:0] GAIN_MAX      = 8'h77;
	localparam logic [6:0] MAX_GAIN_SAT  = 7'h77;
	localparam logic [4:0] NOISE_LIN_END = 5'h07;
	localparam logic [4:0] NOISE_LONG_SH = 5'h07;

	// ----------------------------------------------------------------
	// timing: debounce unit of 0.5 ms at a 5 ns clock
	// ----------------------------------------------------------------
	localparam int          CLK_PERIOD_NS = 5;
	localparam int          DEB_UNIT_NS   = 500000;
	localparam logic [31:0] DEB_UNIT_CYC  = 32'(DEB_UNIT_NS / CLK_PERIOD_NS);

endpackage

// ==== logic/ang_regs.sv ====
/*
 Gain control register bank for the recording path: right noise gate
 control, applied gain readback for both channels, left debounce times,
 and the silence detectors they steer.
 Assumes the control bus front end and the gain loop share i_sys_clk,
 so no input needs a synchroniser.
*/
`timescale 1ns/10ps

// How it works
// - right hysteresis code 0..2 gives 1..3 dB, code 3 turns it off
// - right threshold code zero turns off right noise and silence detection
// - nonzero threshold codes step 2 dB, -30 dB lowest up to -90 dB
// - bit zero of right control enables right clip stepping
// - right control register resets to all zeros
// - left applied gain reads back as signed half-dB value, resets zero
// - right applied gain reads back likewise, same reset, top of range set by right maximum gain
// - left noise debounce codes 0..7 give 0, then 0.5 ms doubling to 32 ms
// - left noise debounce codes 8 and up give 64 ms times (code-7)
// - left signal debounce codes give 0, then 0.5 ms doubling to 32 ms
// - listed debounce times hold only with double-rate audio off
// - right enable input turns right gain control on or off
// - right maximum gain caps applied gain, saturating at 59.5 dB
module ang_regs #(
	parameter logic [31:0] P_DEB_UNIT_CYC = ang_pkg::DEB_UNIT_CYC
) (
	input  wire logic             i_sys_clk,
	input  wire logic             i_reset_n,
	input  wire logic [7:0]       i_reg_addr,
	input  wire logic             i_reg_wr_en,
	input  wire logic [7:0]       i_reg_wr_data,
	input  wire logic             i_reg_rd_en,
	output logic      [7:0]       o_reg_rd_data,
	input  wire logic             i_double_rate_audio_mode,
	input  wire logic             i_right_agc_enable,
	input  wire logic [6:0]       i_right_max_gain,
	input  wire logic             i_left_gain_vld,
	input  wire logic [7:0]       i_left_gain,
	input  wire logic             i_right_gain_vld,
	input  wire logic [7:0]       i_right_gain,
	input  wire logic             i_left_below,
	input  wire logic [6:0]       i_right_level_db,
	output ang_pkg::ang_rcfg_t    o_right_cfg,
	output logic                  o_left_silence,
	output logic                  o_right_silence
);
	import ang_pkg::*;

	ang_rctl_t   rctl_reg;
	ang_dbn_t    dbn_reg;
	logic [7:0]  lgain_reg;
	logic [7:0]  rgain_reg;
	logic [6:0]  cap_c;
	logic [1:0]  hyst_c;
	logic [6:0]  thr_c;
	logic        rdet_en_c;
	logic        rbelow_c;
	logic [31:0] noise_cyc_c;
	logic [31:0] sig_cyc_c;
	logic        rsilent;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// debounce code to cycles; double rate halves the unit
	function automatic logic [31:0] f_deb_cyc(input logic [4:0] code, input logic double_rate_audio_mode);
		logic [31:0] unit;
		unit = double_rate_audio_mode ? (P_DEB_UNIT_CYC >> 1) : P_DEB_UNIT_CYC;
		if (code == 5'h00) begin
			f_deb_cyc = 32'h0;
		end else if (code <= NOISE_LIN_END) begin
			f_deb_cyc = unit << (code - 5'h01);
		end else begin
			f_deb_cyc = (unit << NOISE_LONG_SH) * 32'(code - NOISE_LIN_END);
		end
	endfunction

	// keeps a signed gain inside -12 dB .. hi
	function automatic logic [7:0] f_clamp(input logic [7:0] g, input logic [7:0] hi);
		if ($signed(g) < $signed(GAIN_MIN)) begin
			f_clamp = GAIN_MIN;
		end else if ($signed(g) > $signed(hi)) begin
			f_clamp = hi;
		end else begin
			f_clamp = g;
		end
	endfunction

	// ----------------------------------------------------------------
	// writable registers
	// ----------------------------------------------------------------
	// only the two control registers accept writes
	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			rctl_reg <= RCTL_RST;
			dbn_reg  <= DBN_RST;
		end else if (i_reg_wr_en) begin
			if (i_reg_addr == ADDR_RIGHT_NG_CTRL) begin
				rctl_reg <= ang_rctl_t'(i_reg_wr_data);
			end else if (i_reg_addr == ADDR_LEFT_DEBOUNCE) begin
				dbn_reg <= ang_dbn_t'(i_reg_wr_data);
			end
		end
	end

	// ----------------------------------------------------------------
	// applied gain readback
	// ----------------------------------------------------------------
	// bus writes never reach these; only the gain loop updates them
	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			lgain_reg <= GAIN_RST;
		end else if (i_left_gain_vld) begin
			lgain_reg <= f_clamp(i_left_gain, GAIN_MAX);
		end
	end

	// right gain frozen while the right loop is off
	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			rgain_reg <= GAIN_RST;
		end else if (i_right_gain_vld && i_right_agc_enable) begin
			rgain_reg <= f_clamp(i_right_gain, {1'b0, cap_c});
		end
	end

	// ----------------------------------------------------------------
	// read port
	// ----------------------------------------------------------------
	// data appears one cycle after the read strobe
	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			o_reg_rd_data <= RD_UNMAPPED;
		end else if (i_reg_rd_en) begin
			if (i_reg_addr == ADDR_RIGHT_NG_CTRL) begin
				o_reg_rd_data <= rctl_reg;
			end else if (i_reg_addr == ADDR_LEFT_GAIN) begin
				o_reg_rd_data <= lgain_reg;
			end else if (i_reg_addr == ADDR_RIGHT_GAIN) begin
				o_reg_rd_data <= rgain_reg;
			end else if (i_reg_addr == ADDR_LEFT_DEBOUNCE) begin
				o_reg_rd_data <= dbn_reg;
			end else begin
				o_reg_rd_data <= RD_UNMAPPED;
			end
		end
	end

	// ----------------------------------------------------------------
	// field decode
	// ----------------------------------------------------------------
	assign cap_c     = (i_right_max_gain > MAX_GAIN_SAT) ? MAX_GAIN_SAT : i_right_max_gain;
	assign hyst_c    = (rctl_reg.hyst == HYST_OFF) ? 2'h0 : rctl_reg.hyst + 2'h1;
	assign thr_c     = THR_BASE_DB + {1'b0, rctl_reg.thr, 1'b0};
	assign rdet_en_c = (rctl_reg.thr != THR_OFF) && i_right_agc_enable;
	assign noise_cyc_c = f_deb_cyc(dbn_reg.noise, i_double_rate_audio_mode);
	assign sig_cyc_c   = f_deb_cyc({2'h0, dbn_reg.sig}, i_double_rate_audio_mode);

	// level is attenuation in dB; hysteresis only delays the way back out
	always_comb begin
		if (rsilent) begin
			rbelow_c = ({1'b0, i_right_level_db} + {6'h00, hyst_c}) >= {1'b0, thr_c};
		end else begin
			rbelow_c = i_right_level_db > thr_c;
		end
	end

	// ----------------------------------------------------------------
	// decoded settings out
	// ----------------------------------------------------------------
	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			o_right_cfg <= '0;
		end else begin
			o_right_cfg.noise_det_en <= rdet_en_c;
			o_right_cfg.hyst_db      <= hyst_c;
			o_right_cfg.thr_db       <= rdet_en_c ? thr_c : 7'h00;
			o_right_cfg.clip_en      <= rctl_reg.clip;
			o_right_cfg.agc_active   <= i_right_agc_enable;
			o_right_cfg.gain_cap     <= cap_c;
		end
	end

	// ----------------------------------------------------------------
	// silence detectors
	// ----------------------------------------------------------------
	// the right debounce times live elsewhere, so right runs undebounced
	ang_debounce u_left_db (
		.i_sys_clk   (i_sys_clk),
		.i_reset_n   (i_reset_n),
		.i_en        (1'b1),
		.i_below     (i_left_below),
		.i_noise_cyc (noise_cyc_c),
		.i_sig_cyc   (sig_cyc_c),
		.o_silent    (o_left_silence)
	);

	ang_debounce u_right_db (
		.i_sys_clk   (i_sys_clk),
		.i_reset_n   (i_reset_n),
		.i_en        (rdet_en_c),
		.i_below     (rbelow_c),
		.i_noise_cyc (32'h0),
		.i_sig_cyc   (32'h0),
		.o_silent    (rsilent)
	);

	assign o_right_silence = rsilent;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_hyst_map;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		(rctl_reg.hyst == HYST_OFF) |=> (o_right_cfg.hyst_db == 2'h0);
	endproperty
	a_hyst_map: assert property (p_hyst_map) else $error("hysteresis not off for code 3");

	property p_noise_off;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		(rctl_reg.thr == THR_OFF) |=> !o_right_cfg.noise_det_en && !o_right_silence;
	endproperty
	a_noise_off: assert property (p_noise_off) else $error("right detection not off");

	property p_thr_step;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		(rdet_en_c && rctl_reg.thr == 5'h1F) |=> (o_right_cfg.thr_db == 7'h5A);
	endproperty
	a_thr_step: assert property (p_thr_step) else $error("top threshold not 90 dB");

	property p_clip_write;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		(i_reg_wr_en && i_reg_addr == ADDR_RIGHT_NG_CTRL) |=> ##1 (o_right_cfg.clip_en == $past(i_reg_wr_data[0], 2));
	endproperty
	a_clip_write: assert property (p_clip_write) else $error("clip stepping not following write");

	property p_reset_ctl;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		$rose(i_reset_n) |-> (rctl_reg == RCTL_RST) && (lgain_reg == GAIN_RST) && (rgain_reg == GAIN_RST);
	endproperty
	a_reset_ctl: assert property (p_reset_ctl) else $error("registers not zero after reset");

	property p_lgain_ro;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		(i_reg_wr_en && i_reg_addr == ADDR_LEFT_GAIN && !i_left_gain_vld) |=> $stable(lgain_reg);
	endproperty
	a_lgain_ro: assert property (p_lgain_ro) else $error("left gain changed by write");

	property p_lgain_track;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		(i_left_gain_vld && $signed(i_left_gain) >= $signed(GAIN_MIN) && $signed(i_left_gain) <= $signed(GAIN_MAX))
			|=> (lgain_reg == $past(i_left_gain));
	endproperty
	a_lgain_track: assert property (p_lgain_track) else $error("left gain not tracking loop");

	property p_rgain_read;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		(i_reg_rd_en && i_reg_addr == ADDR_RIGHT_GAIN) |=> (o_reg_rd_data == $past(rgain_reg));
	endproperty
	a_rgain_read: assert property (p_rgain_read) else $error("right gain readback wrong");

	property p_noise_long;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		(dbn_reg.noise == 5'h1F && !i_double_rate_audio_mode) |-> (noise_cyc_c == P_DEB_UNIT_CYC * 32'd3072);
	endproperty
	a_noise_long: assert property (p_noise_long) else $error("longest noise debounce wrong");

	property p_sig_short;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		(dbn_reg.sig == 3'h7 && !i_double_rate_audio_mode) |-> (sig_cyc_c == P_DEB_UNIT_CYC * 32'd64);
	endproperty
	a_sig_short: assert property (p_sig_short) else $error("32 ms signal debounce wrong");

	property p_dra_half;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		(dbn_reg.sig == 3'h1 && i_double_rate_audio_mode) |-> (sig_cyc_c == (P_DEB_UNIT_CYC >> 1));
	endproperty
	a_dra_half: assert property (p_dra_half) else $error("double rate scaling wrong");

	property p_rgain_cap;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		(i_right_gain_vld && i_right_agc_enable && $signed(i_right_gain) > $signed({1'b0, cap_c}))
			|=> (rgain_reg == {1'b0, $past(cap_c)});
	endproperty
	a_rgain_cap: assert property (p_rgain_cap) else $error("right gain above cap");

	property p_right_off;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		!i_right_agc_enable |=> $stable(rgain_reg) && !o_right_cfg.agc_active;
	endproperty
	a_right_off: assert property (p_right_off) else $error("right loop active while off");

	property p_hyst_step;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		(rctl_reg.hyst != HYST_OFF) |=> (o_right_cfg.hyst_db == $past(rctl_reg.hyst) + 2'h1);
	endproperty
	a_hyst_step: assert property (p_hyst_step) else $error("hysteresis step wrong");

	property p_lgain_floor;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		(i_left_gain_vld && $signed(i_left_gain) < $signed(GAIN_MIN)) |=> (lgain_reg == GAIN_MIN);
	endproperty
	a_lgain_floor: assert property (p_lgain_floor) else $error("left gain below floor");

	property p_rgain_ro;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		(i_reg_wr_en && i_reg_addr == ADDR_RIGHT_GAIN && !(i_right_gain_vld && i_right_agc_enable))
			|=> $stable(rgain_reg);
	endproperty
	a_rgain_ro: assert property (p_rgain_ro) else $error("right gain changed by write");

endmodule
